// *** design/ied_dispatch.sv ***
// Interrupt and exception dispatch unit of the processor core.
// Assumes the core signals instruction boundaries, exceptions and returns on CLK,
// a stack unit acknowledges pushes, and a bus unit runs the acknowledge cycle.
module ied_dispatch
    import ied_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic              CLK,
    input  wire logic              RST_N,
    input  wire logic              CE,
    // Instruction progress from the core.
    input  wire logic              INSTR_DONE,
    input  wire logic [ADDR_W-1:0] INSTR_START,
    input  wire logic [ADDR_W-1:0] INSTR_NEXT,
    input  wire logic [ADDR_W-1:0] FLAGS_WORD,
    input  wire ied_exc_t          EXC_REQ,
    // Enable flag control from the core.
    input  wire logic              IF_WRITE,
    input  wire logic              IF_VALUE,
    input  wire logic              INTERRUPT_RETURN_INSTRUCTION_DONE,
    input  wire logic              INTERRUPT_RETURN_INSTRUCTION_IF,
    // Mode and table base.
    input  wire logic              PROT_MODE,
    input  wire logic [ADDR_W-1:0] TABLE_BASE,
    // External request pins.
    input  wire logic              MASKABLE_REQUEST_INPUT,
    input  wire logic              NMI_REQUEST,
    // Acknowledge cycle with the bus unit.
    output logic                   ACK_START,
    input  wire logic              ACK_DONE,
    input  wire logic [VEC_W-1:0]  ACK_VECTOR,
    // Stack unit.
    output ied_push_t              PUSH,
    input  wire logic              PUSH_DONE,
    // Results to the core.
    output logic                   CANCEL_INSTR,
    output ied_disp_t              DISPATCH,
    output logic                   IF_FLAG,
    output logic                   NMI_BLOCKED,
    output logic                   BUSY
);

    // Sequencer states. The vector state costs one cycle, but it lets ACK_START
    // come straight from a flop rather than from the push handshake decode.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PUSH,
        ST_VECTOR,
        ST_ACK,
        ST_ENTRY
    } ied_state_t;

    // Table entry address for a vector in the current mode.
    function automatic logic [ADDR_W-1:0] entry_of(input logic [VEC_W-1:0] v,
                                                  input logic prot,
                                                  input logic [ADDR_W-1:0] base);
        logic [ADDR_W-1:0] off;
        off = {{(ADDR_W-VEC_W){1'b0}}, v};
        if (prot) begin
            off = off << PROT_ENTRY_SHIFT;
        end else begin
            off = off << REAL_ENTRY_SHIFT;
        end
        return base + off;
    endfunction : entry_of

    // Dispatch context, held from acceptance until the entry lookup.
    ied_state_t        state;
    ied_src_t          src;
    logic [VEC_W-1:0]  vec;
    logic              precise;
    logic [1:0]        mask_sync;
    logic [1:0]        nmi_sync;
    logic              nmi_prev;
    logic              nmi_pending;
    logic              nmi_active;
    logic              nmi_edge;
    logic              take_fault;
    logic              take_trap;
    logic              take_nmi;
    logic              take_mask;
    logic              start;

    // Both request pins are asynchronous to CLK and pass two flops first.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mask_sync <= 2'h0;
            nmi_sync  <= 2'h0;
            nmi_prev  <= 1'b0;
        end else if (CE) begin
            mask_sync <= {mask_sync[0], MASKABLE_REQUEST_INPUT};
            nmi_sync  <= {nmi_sync[0], NMI_REQUEST};
            nmi_prev  <= nmi_sync[1];
        end
    end

    // Only the second synchroniser stage feeds the edge detector.
    assign nmi_edge = nmi_sync[1] & ~nmi_prev;

    // Faults and aborts cut into the instruction; traps wait for its completion.
    assign take_fault = EXC_REQ.valid && EXC_REQ.cls != IED_TRAP;
    assign take_trap  = EXC_REQ.valid && EXC_REQ.cls == IED_TRAP
                        && INSTR_DONE;
    // The non-maskable request wins over a maskable one at the same boundary.
    assign take_nmi   = INSTR_DONE && nmi_pending && !nmi_active;
    assign take_mask  = INSTR_DONE && mask_sync[1] && IF_FLAG;
    // Exceptions and maskable requests are not queued while busy, so the core must hold an exception until BUSY.
    assign start      = state == ST_IDLE && (take_fault || take_trap
                        || take_nmi || take_mask);

    // A pending request survives an acceptance in the same cycle as a new edge.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            nmi_pending <= 1'b0;
        end else if (CE) begin
            if (nmi_edge) begin
                nmi_pending <= 1'b1;
            end else if (start && !take_fault && !take_trap && take_nmi) begin
                nmi_pending <= 1'b0;
            end
        end
    end

    // The handler-active flag blocks further non-maskable servicing until the return.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            nmi_active <= 1'b0;
        end else if (CE) begin
            if (start && !take_fault && !take_trap && take_nmi) begin
                nmi_active <= 1'b1;
            end else if (INTERRUPT_RETURN_INSTRUCTION_DONE) begin
                nmi_active <= 1'b0;
            end
        end
    end

    // Enable flag: cleared on entry, restored on return, else software writes.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            IF_FLAG <= IF_RESET;
        end else if (CE) begin
            if (start) begin
                IF_FLAG <= 1'b0;
            end else if (INTERRUPT_RETURN_INSTRUCTION_DONE) begin
                IF_FLAG <= INTERRUPT_RETURN_INSTRUCTION_IF;
            end else if (IF_WRITE) begin
                IF_FLAG <= IF_VALUE;
            end
        end
    end

    // Sequencer: push state, obtain vector, then look up the handler entry.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= ST_IDLE;
        end else if (CE) begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state <= ST_PUSH;
                    end
                end
                ST_PUSH: begin
                    if (PUSH_DONE) begin
                        state <= ST_VECTOR;
                    end
                end
                ST_VECTOR: begin
                    // Internal and instruction vectors are already known here.
                    if (src == IED_SRC_MASK) begin
                        state <= ST_ACK;
                    end else begin
                        state <= ST_ENTRY;
                    end
                end
                ST_ACK: begin
                    // The controller may stretch its answer; no limit is put on the wait.
                    if (ACK_DONE) begin
                        state <= ST_ENTRY;
                    end
                end
                ST_ENTRY: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Capture source, vector and return words when an event is accepted.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            src     <= IED_SRC_EXC;
            vec     <= VEC_RESET;
            precise <= 1'b1;
            PUSH    <= '0;
        end else if (CE) begin
            if (start) begin
                PUSH.valid <= 1'b1;
                PUSH.flags <= FLAGS_WORD;
                if (take_fault) begin
                    src           <= IED_SRC_EXC;
                    vec           <= EXC_REQ.vec;
                    precise       <= EXC_REQ.cls == IED_FAULT;
                    PUSH.ret_addr <= INSTR_START;
                end else if (take_trap) begin
                    src           <= IED_SRC_EXC;
                    vec           <= EXC_REQ.vec;
                    precise       <= 1'b1;
                    PUSH.ret_addr <= INSTR_NEXT;
                end else if (take_nmi) begin
                    src           <= IED_SRC_NMI;
                    vec           <= VEC_NMI;
                    precise       <= 1'b1;
                    PUSH.ret_addr <= INSTR_NEXT;
                end else begin
                    // The maskable vector arrives later, from the acknowledge cycle.
                    src           <= IED_SRC_MASK;
                    precise       <= 1'b1;
                    PUSH.ret_addr <= INSTR_NEXT;
                end
            end else if (state == ST_PUSH && PUSH_DONE) begin
                PUSH.valid <= 1'b0;
            end else if (state == ST_ACK && ACK_DONE) begin
                vec <= ACK_VECTOR;
            end
        end
    end

    // The acknowledge request is a one-cycle pulse, maskable source only.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ACK_START <= 1'b0;
        end else if (CE) begin
            ACK_START <= state == ST_VECTOR && src == IED_SRC_MASK;
        end
    end

    // A fault or abort tells the core to drop the instruction so it can restart.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            CANCEL_INSTR <= 1'b0;
        end else if (CE) begin
            CANCEL_INSTR <= start && take_fault;
        end
    end

    // Handler entry lookup, one-cycle valid pulse after the vector is known.
    // Fields other than valid hold their value until the next lookup.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            DISPATCH <= '0;
        end else if (CE) begin
            DISPATCH.valid <= state == ST_ENTRY;
            if (state == ST_ENTRY) begin
                DISPATCH.vec          <= vec;
                DISPATCH.entry_addr   <= entry_of(vec, PROT_MODE, TABLE_BASE);
                DISPATCH.precise      <= precise;
                // An external vector in the reserved range is flagged for software.
                DISPATCH.reserved_vec <= src == IED_SRC_MASK
                                         && vec < VEC_FIRST_FREE;
            end
        end
    end

    // Status outputs, registered so the core sees glitch-free levels.
    // BUSY rises with the acceptance itself, on the same edge that moves the sequencer out of ST_IDLE.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            NMI_BLOCKED <= 1'b0;
            BUSY        <= 1'b0;
        end else if (CE) begin
            NMI_BLOCKED <= nmi_active;
            BUSY        <= state != ST_IDLE || start;
        end
    end

endmodule : ied_dispatch

// *** design/ied_pkg.sv ***
// Shared constants and carrier types for the interrupt and exception dispatch unit.
// Assumes a 32-bit linear address space and an 8-bit vector number.
package ied_pkg;

    // Address and vector widths.
    localparam int ADDR_W = 32;
    localparam int VEC_W  = 8;

    // Vector numbering.
    localparam logic [VEC_W-1:0] VEC_NMI        = 8'h02;
    localparam logic [VEC_W-1:0] VEC_FIRST_FREE = 8'h20;

    // Entry size as a left shift of the vector number, per mode.
    localparam logic [1:0] REAL_ENTRY_SHIFT = 2'h2;
    localparam logic [1:0] PROT_ENTRY_SHIFT = 2'h3;

    // Reset values.
    localparam logic              IF_RESET   = 1'b0;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
    localparam logic [VEC_W-1:0]  VEC_RESET  = 8'h00;

    // Exception classes reported by the core.
    typedef enum logic [1:0] {
        IED_FAULT,
        IED_TRAP,
        IED_ABORT
    } ied_class_t;

    // Event source of the dispatch in progress.
    typedef enum logic [1:0] {
        IED_SRC_EXC,
        IED_SRC_NMI,
        IED_SRC_MASK
    } ied_src_t;

    // Exception or software interrupt request from the core.
    typedef struct packed {
        logic               valid;
        ied_class_t         cls;
        logic [VEC_W-1:0]   vec;
    } ied_exc_t;

    // Words handed to the stack unit.
    typedef struct packed {
        logic               valid;
        logic [ADDR_W-1:0]  ret_addr;
        logic [ADDR_W-1:0]  flags;
    } ied_push_t;

    // Handler entry lookup handed to the fetch unit.
    typedef struct packed {
        logic               valid;
        logic [VEC_W-1:0]   vec;
        logic [ADDR_W-1:0]  entry_addr;
        logic               precise;
        logic               reserved_vec;
    } ied_disp_t;

endpackage : ied_pkg

// *** dv/ied_ctrl_model.sv ***
// Behavioural model of the external interrupt controller that answers acknowledge cycles.
// Assumes the bench supplies the vector to return and the extra wait for each answer.
module ied_ctrl_model
    import ied_pkg::*;
(
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Vector to return and extra wait cycles.
    input  wire logic [VEC_W-1:0] vec_in,
    input  wire logic [1:0]       wait_n,
    // Acknowledge cycle.
    input  wire logic             ack_start,
    output logic                  ack_done,
    output logic [VEC_W-1:0]      ack_vector
);
    timeunit 1ns;
    timeprecision 1ps;
    // Answer after the wait; after each answer the vector lines carry the inverse value,
    // so a design that samples late sees garbage rather than a lucky match.
    initial begin
        ack_done = 1'b0;
        ack_vector = 8'hA5;
        forever begin
            @(posedge clk);
            if (rst_n && ack_start) begin
                repeat (wait_n) @(posedge clk);
                @(negedge clk);
                ack_done = 1'b1;
                ack_vector = vec_in;
                @(negedge clk);
                ack_done = 1'b0;
                ack_vector = ~vec_in;
            end
        end
    end
endmodule : ied_ctrl_model

// *** dv/ied_dispatch_chk.sv ***
// Concurrent checks on the ports of the dispatch unit.
// Assumes CE stays high, so every cycle is an active cycle.
module ied_dispatch_chk
    import ied_pkg::*;
(
    // Clock and reset.
    input wire logic              CLK,
    input wire logic              RST_N,
    // Core side.
    input wire logic              INSTR_DONE,
    input wire logic [ADDR_W-1:0] INSTR_START,
    input wire logic [ADDR_W-1:0] INSTR_NEXT,
    input wire logic              PROT_MODE,
    input wire logic [ADDR_W-1:0] TABLE_BASE,
    // Acknowledge, stack and results.
    input wire logic              ACK_START,
    input wire logic              ACK_DONE,
    input wire logic [VEC_W-1:0]  ACK_VECTOR,
    input wire ied_push_t         PUSH,
    input wire logic              CANCEL_INSTR,
    input wire ied_disp_t         DISPATCH,
    input wire logic              IF_FLAG,
    input wire logic              BUSY
);
    logic             ack_seen;
    logic [VEC_W-1:0] ack_vec;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    // Tracks whether the dispatch in flight ran an acknowledge cycle, and its vector.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ack_seen <= 1'b0;
        end else if (DISPATCH.valid) begin
            ack_seen <= 1'b0;
        end else if (ACK_START) begin
            ack_seen <= 1'b1;
        end
    end
    // Captures the returned vector.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ack_vec <= VEC_RESET;
        end else if (ACK_DONE) begin
            ack_vec <= ACK_VECTOR;
        end
    end
    ack_vec_a: assert property (DISPATCH.valid && ack_seen |-> DISPATCH.vec == ack_vec)
        else $error("dispatched vector differs from acknowledged vector");
    rsv_vec_a: assert property (DISPATCH.valid && ack_seen |->
        DISPATCH.reserved_vec == (DISPATCH.vec < VEC_FIRST_FREE))
        else $error("reserved flag wrong for external vector");
    internal_rsv_a: assert property (DISPATCH.valid && !ack_seen |-> !DISPATCH.reserved_vec)
        else $error("internal vector marked reserved");
    entry_addr_a: assert property (DISPATCH.valid |-> DISPATCH.entry_addr == $past(TABLE_BASE)
        + (ADDR_W'(DISPATCH.vec) << ($past(PROT_MODE) ? 3 : 2)))
        else $error("entry address wrong");
    push_first_a: assert property (ACK_START |-> !PUSH.valid && BUSY)
        else $error("acknowledge started before push completed");
    vec_then_entry_a: assert property (ACK_DONE |-> ##[1:4] DISPATCH.valid)
        else $error("no dispatch after vector returned");
    fault_ret_a: assert property (CANCEL_INSTR |->
        PUSH.valid && PUSH.ret_addr == $past(INSTR_START))
        else $error("fault return address wrong");
    next_ret_a: assert property ($rose(BUSY) && !CANCEL_INSTR |->
        $past(INSTR_DONE) && PUSH.ret_addr == $past(INSTR_NEXT))
        else $error("boundary event return address wrong");
    if_clear_a: assert property ($rose(BUSY) |-> !IF_FLAG)
        else $error("enable flag not cleared on service");
    cover property (DISPATCH.valid && ack_seen);
    cover property (CANCEL_INSTR);
    cover property (DISPATCH.valid && !DISPATCH.precise);
endmodule : ied_dispatch_chk

bind ied_dispatch ied_dispatch_chk i_ied_dispatch_chk (.CLK(CLK), .RST_N(RST_N),
    .INSTR_DONE(INSTR_DONE), .INSTR_START(INSTR_START), .INSTR_NEXT(INSTR_NEXT),
    .PROT_MODE(PROT_MODE), .TABLE_BASE(TABLE_BASE), .ACK_START(ACK_START),
    .ACK_DONE(ACK_DONE), .ACK_VECTOR(ACK_VECTOR), .PUSH(PUSH), .CANCEL_INSTR(CANCEL_INSTR),
    .DISPATCH(DISPATCH), .IF_FLAG(IF_FLAG), .BUSY(BUSY));

// *** dv/ied_dispatch_bench.sv ***
// Self-checking bench for the dispatch unit with a controller model and a stack stub.
// Assumes the design answers within 200 cycles of each request.
`define CHK(g, w) begin cmp_count++; if ((g) !== (w)) begin fails++; \
    $display("wrong value at %0t: got %0h want %0h", $time, g, w); end end
module ied_dispatch_bench;
    import ied_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [31:0] ret;
        logic [31:0] flags;
        logic [7:0]  vec;
        logic [31:0] entry;
        logic        precise;
        logic        rsv;
    } ied_exp_t;
    logic        clk, rst_n, instr_done, if_write, if_value, interrupt_return_instruction_done, interrupt_return_instruction_if, prot_mode;
    logic        mask_pin, nmi_pin, push_done, ack_start, ack_done, cancel_instr, if_flag;
    logic        nmi_blocked, busy;
    logic [31:0] instr_start, instr_next, flags_word, table_base;
    logic [7:0]  ack_vector, ctrl_vec;
    logic [1:0]  ctrl_wait;
    ied_exc_t    exc_req;
    ied_push_t   push, got_push;
    ied_disp_t   disp;
    ied_exp_t    exp_q[$], mon_e;
    int          fails = 0, cmp_count = 0, acks = 0, cancels = 0, n;
    integer      seed = 32'heb9f5f94;
    logic [7:0]  vl[4] = '{8'h00, 8'h1F, 8'h20, 8'hFF};

    ied_dispatch i_ied_dispatch (.CLK(clk), .RST_N(rst_n), .CE(1'b1),
        .INSTR_DONE(instr_done), .INSTR_START(instr_start), .INSTR_NEXT(instr_next),
        .FLAGS_WORD(flags_word), .EXC_REQ(exc_req), .IF_WRITE(if_write), .IF_VALUE(if_value),
        .INTERRUPT_RETURN_INSTRUCTION_DONE(interrupt_return_instruction_done), .INTERRUPT_RETURN_INSTRUCTION_IF(interrupt_return_instruction_if), .PROT_MODE(prot_mode),
        .TABLE_BASE(table_base), .MASKABLE_REQUEST_INPUT(mask_pin), .NMI_REQUEST(nmi_pin),
        .ACK_START(ack_start), .ACK_DONE(ack_done), .ACK_VECTOR(ack_vector), .PUSH(push),
        .PUSH_DONE(push_done), .CANCEL_INSTR(cancel_instr), .DISPATCH(disp),
        .IF_FLAG(if_flag), .NMI_BLOCKED(nmi_blocked), .BUSY(busy));
    ied_ctrl_model i_ied_ctrl_model (.clk(clk), .rst_n(rst_n), .vec_in(ctrl_vec),
        .wait_n(ctrl_wait), .ack_start(ack_start), .ack_done(ack_done), .ack_vector(ack_vector));

    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Stack stub: acknowledges pushes after a random stall.
    always @(negedge clk) push_done <= push.valid && ($random(seed) & 1);
    // Monitor: keeps the pushed words and checks each dispatch against the oldest note.
    always @(posedge clk) begin
        if (ack_start === 1'b1) acks++;
        if (cancel_instr === 1'b1) cancels++;
        if (push.valid === 1'b1) got_push = push;
        if (disp.valid === 1'b1) begin
            if (exp_q.size() == 0) `CHK(disp.valid, 1'b0)
            else begin
                mon_e = exp_q.pop_front();
                `CHK(disp.vec, mon_e.vec)
                `CHK(disp.entry_addr, mon_e.entry)
                `CHK(disp.precise, mon_e.precise)
                `CHK(disp.reserved_vec, mon_e.rsv)
                `CHK(got_push.ret_addr, mon_e.ret)
                `CHK(got_push.flags, mon_e.flags)
            end
        end
    end

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run
    task automatic wait_busy(input logic v);
        int k;
        for (k = 0; k < 200 && busy !== v; k++) @(negedge clk);
        if (busy !== v) begin
            fails++;
            complete_run();
        end
    endtask : wait_busy
    // Kinds: 0 fault, 1 trap, 2 abort, 3 maskable, 4 non-maskable.
    task automatic prep(input int kind, input logic [7:0] vec);
        ied_exp_t e;
        @(negedge clk);
        instr_start = $random(seed);
        instr_next = instr_start + 32'h3;
        flags_word = $random(seed);
        table_base = $random(seed);
        prot_mode = 1'($random(seed));
        ctrl_vec = vec;
        ctrl_wait = 2'($random(seed));
        e.ret = (kind == 0 || kind == 2) ? instr_start : instr_next;
        e.flags = flags_word;
        e.vec = (kind == 4) ? VEC_NMI : vec;
        e.entry = table_base + (32'(e.vec) << (prot_mode ? 3 : 2));
        e.precise = (kind != 2);
        e.rsv = (kind == 3) && (vec < VEC_FIRST_FREE);
        exp_q.push_back(e);
        exc_req.valid = (kind < 3);
        exc_req.cls = ied_class_t'(kind[1:0]);
        exc_req.vec = vec;
        instr_done = (kind == 1 || kind > 2);
        mask_pin = (kind == 3);
        nmi_pin = (kind == 4);
    endtask : prep
    task automatic go;
        wait_busy(1'b1);
        exc_req.valid = 1'b0;
        instr_done = 1'b0;
        mask_pin = 1'b0;
        nmi_pin = 1'b0;
        wait_busy(1'b0);
    endtask : go
    task automatic pulse(input logic wr, input logic ir, input logic v);
        @(negedge clk);
        if_write = wr;
        interrupt_return_instruction_done = ir;
        if_value = v;
        interrupt_return_instruction_if = v;
        @(negedge clk);
        if_write = 1'b0;
        interrupt_return_instruction_done = 1'b0;
    endtask : pulse
    task automatic idle_check(input logic mp, input logic dn);
        @(negedge clk);
        mask_pin = mp;
        instr_done = dn;
        repeat (8) @(negedge clk);
        `CHK(busy, 1'b0)
        mask_pin = 1'b0;
        instr_done = 1'b0;
    endtask : idle_check

    // Main sequence.
    initial begin
        {rst_n, instr_done, if_write, if_value, interrupt_return_instruction_done, interrupt_return_instruction_if, prot_mode} = '0;
        {mask_pin, nmi_pin, ctrl_vec, ctrl_wait, exc_req} = '0;
        {instr_start, instr_next, flags_word, table_base} = '0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        `CHK(if_flag, IF_RESET)
        idle_check(1'b1, 1'b1);
        pulse(1'b1, 1'b0, 1'b1);
        idle_check(1'b1, 1'b0);
        for (int i = 0; i < 8; i++) begin
            prep(3, i < 4 ? vl[i] : 8'($random(seed)));
            go();
            `CHK(if_flag, 1'b0)
            pulse(1'b1, 1'b0, 1'b1);
        end
        for (int i = 0; i < 9; i++) begin
            prep(i % 3, i < 3 ? 8'h0E : 8'($random(seed)));
            go();
        end
        `CHK(cancels, 6)
        n = acks;
        prep(4, 8'h00);
        go();
        `CHK(nmi_blocked, 1'b1)
        `CHK(acks, n)
        prep(4, 8'h00);
        repeat (8) @(negedge clk);
        `CHK(busy, 1'b0)
        nmi_pin = 1'b0;
        instr_done = 1'b0;
        pulse(1'b0, 1'b1, 1'b1);
        `CHK(if_flag, 1'b1)
        instr_done = 1'b1;
        go();
        pulse(1'b0, 1'b1, 1'b0);
        repeat (4) @(negedge clk);
        `CHK(exp_q.size(), 0)
        complete_run();
    end
endmodule : ied_dispatch_bench
